// File: logic/amsk_pkg.sv
// Notes on behaviour
// - upper seek limit 16 bits, default 1710
// - seek at limit halts or wraps per command
// - controller keeps upper limit within 149..23000
// - controller rewrites upper limit after power-up
// - spacing low four bits; only 1,5,9,10
// - each seek step moves by programmed spacing unless it would pass a band edge
// - snr threshold six bits, default 5, zero ignores
// - rssi threshold six bits, default 25, zero ignores
// - channel valid by comparing snr and rssi
// - clear-to-send raised after each property access
// - properties accessed only while powered up
// - volume six bits, default 63 maximum
// - either mute bit silences both channels
`default_nettype none
package amsk_pkg;
	// ----------------------------------------
	// property identifiers and resets
	// ----------------------------------------
	localparam logic [15:0] PROP_UPPER = 16'h3401;
	localparam logic [15:0] PROP_SPACE = 16'h3402;
	localparam logic [15:0] PROP_SNR = 16'h3403;
	localparam logic [15:0] PROP_RSSI = 16'h3404;
	localparam logic [15:0] PROP_VOL = 16'h4000;
	localparam logic [15:0] PROP_MUTE = 16'h4001;
	localparam logic [15:0] UPPER_RST = 16'h06AE;
	localparam logic [3:0] SPACE_RST = 4'hA;
	localparam logic [5:0] SNR_RST = 6'h05;
	localparam logic [5:0] RSSI_RST = 6'h19;
	localparam logic [5:0] VOL_RST = 6'h3F;
	localparam logic [1:0] MUTE_RST = 2'h0;
	localparam int SPACE_W = 4;
	localparam int LVL_W = 6;
	localparam int LEFT_BIT = 1;
	localparam int RIGHT_BIT = 0;
	// legal values the controller enforces
	localparam logic [15:0] UPPER_MIN = 16'h0095;
	localparam logic [15:0] UPPER_MAX = 16'h59D8;
	localparam logic [3:0] SPACE_1 = 4'h1;
	localparam logic [3:0] SPACE_5 = 4'h5;
	localparam logic [3:0] SPACE_9 = 4'h9;
	localparam logic [3:0] SPACE_10 = 4'hA;
	// cycles the device stays busy after taking a command
	localparam int CMD_BUSY_CYC = 4;
	// ----------------------------------------
	// controller apb map
	// ----------------------------------------
	localparam logic [7:0] REG_PROP = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_INT_STAT = 8'h14;
	localparam logic [7:0] REG_INT_MASK = 8'h18;
	localparam int CTRL_GO = 0;
	localparam int CTRL_WR = 1;
	localparam int ST_BUSY = 0;
	localparam int ST_PWR = 1;
	localparam int ST_ERR = 2;
	localparam int ST_FIXED = 3;
	localparam int INT_DONE = 0;
	localparam int INT_ERR = 1;
	localparam int INT_FIX = 2;
	localparam int INT_W = 3;
endpackage : amsk_pkg
`default_nettype wire

// File: logic/amsk_if.sv
`timescale 1ns/10ps
`default_nettype none
interface amsk_if;
	logic cmd_valid;
	logic cmd_wr;
	logic [15:0] cmd_prop;
	logic [15:0] cmd_data;
	logic cts;
	logic rsp_valid;
	logic rsp_err;
	logic [15:0] rsp_data;
	logic powered;
	modport dev (
		input cmd_valid, cmd_wr, cmd_prop, cmd_data,
		output cts, rsp_valid, rsp_err, rsp_data, powered
	);
	modport ctl (
		output cmd_valid, cmd_wr, cmd_prop, cmd_data,
		input cts, rsp_valid, rsp_err, rsp_data, powered
	);
endinterface : amsk_if
`default_nettype wire

// File: logic/amsk_dev.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module amsk_dev (
	input wire logic clk,
	input wire logic rstn,
	amsk_if.dev link,
	input wire logic pwr_on,
	input wire logic pwr_off,
	input wire logic seek_start,
	input wire logic seek_up,
	input wire logic seek_wrap,
	input wire logic tune_start,
	input wire logic [15:0] tune_khz,
	input wire logic [15:0] band_low_khz,
	input wire logic meas_strobe,
	input wire logic [5:0] meas_snr,
	input wire logic [5:0] meas_rssi,
	output logic [15:0] tuned_khz,
	output logic seek_busy,
	output logic seek_done,
	output logic chan_valid,
	output logic [5:0] loudness_level,
	output logic audio_mute,
	output logic cts_irq
);
	typedef enum logic [1:0] {SK_IDLE, SK_SEEK, SK_TUNE} amsk_seek_e;

	logic pwr_q;
	logic cts_q;
	logic rsp_valid_q;
	logic rsp_err_q;
	logic [15:0] rsp_data_q;
	logic [2:0] busy_cnt_q;
	logic [15:0] upper_limit_khz_q;
	logic [3:0] step_spacing_khz_q;
	logic [5:0] valid_snr_level_q;
	logic [5:0] valid_strength_level_q;
	logic [5:0] loudness_level_q;
	logic left_silence_bit_q;
	logic right_silence_bit_q;
	logic audio_mute_q;
	logic cts_irq_q;
	amsk_seek_e sk_q;
	logic [15:0] tuned_q;
	logic [15:0] start_q;
	logic up_q;
	logic wrap_q;
	logic wrapped_q;
	logic done_q;
	logic valid_q;
	logic take;
	logic space_ok;
	logic known;
	logic meas_ok;
	logic [16:0] up_nxt;
	logic [16:0] dn_floor;
	logic [15:0] dn_nxt;
	logic past_top;
	logic past_low;
	logic hit_start;

	assign take = link.cmd_valid && cts_q;
	assign link.cts = cts_q;
	assign link.rsp_valid = rsp_valid_q;
	assign link.rsp_err = rsp_err_q;
	assign link.rsp_data = rsp_data_q;
	assign link.powered = pwr_q;
	assign tuned_khz = tuned_q;
	assign seek_busy = (sk_q != SK_IDLE);
	assign seek_done = done_q;
	assign chan_valid = valid_q;
	assign loudness_level = loudness_level_q;
	assign audio_mute = audio_mute_q;
	assign cts_irq = cts_irq_q;

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	always_comb begin
		space_ok = (link.cmd_data[3:0] == amsk_pkg::SPACE_1) ||
			(link.cmd_data[3:0] == amsk_pkg::SPACE_5) ||
			(link.cmd_data[3:0] == amsk_pkg::SPACE_9) ||
			(link.cmd_data[3:0] == amsk_pkg::SPACE_10);
		unique case (link.cmd_prop)
			amsk_pkg::PROP_UPPER, amsk_pkg::PROP_SPACE,
			amsk_pkg::PROP_SNR, amsk_pkg::PROP_RSSI,
			amsk_pkg::PROP_VOL, amsk_pkg::PROP_MUTE: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// ----------------------------------------
	// power state
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwr_q <= 1'b0;
		end else if (pwr_off) begin
			pwr_q <= 1'b0;
		end else if (pwr_on) begin
			pwr_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// clear-to-send and response
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cts_q <= 1'b1;
			busy_cnt_q <= 3'h0;
			rsp_valid_q <= 1'b0;
			cts_irq_q <= 1'b0;
		end else begin
			rsp_valid_q <= 1'b0;
			cts_irq_q <= 1'b0;
			if (take) begin
				cts_q <= 1'b0;
				busy_cnt_q <= 3'(amsk_pkg::CMD_BUSY_CYC - 1);
			end else if (!cts_q && busy_cnt_q != 3'h0) begin
				busy_cnt_q <= busy_cnt_q - 3'h1;
			end else if (!cts_q) begin
				cts_q <= 1'b1;
				rsp_valid_q <= 1'b1;
				cts_irq_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsp_err_q <= 1'b0;
			rsp_data_q <= 16'h0000;
		end else if (take) begin
			rsp_err_q <= !pwr_q || !known ||
				(link.cmd_wr && link.cmd_prop == amsk_pkg::PROP_SPACE
				&& !space_ok);
			rsp_data_q <= 16'h0000;
			if (pwr_q && !link.cmd_wr) begin
				unique case (link.cmd_prop)
					amsk_pkg::PROP_UPPER: rsp_data_q <= upper_limit_khz_q;
					amsk_pkg::PROP_SPACE: rsp_data_q <= {12'h000,
						step_spacing_khz_q};
					amsk_pkg::PROP_SNR: rsp_data_q <= {10'h000,
						valid_snr_level_q};
					amsk_pkg::PROP_RSSI: rsp_data_q <= {10'h000,
						valid_strength_level_q};
					amsk_pkg::PROP_VOL: rsp_data_q <= {10'h000,
						loudness_level_q};
					amsk_pkg::PROP_MUTE: rsp_data_q <= {14'h0000,
						left_silence_bit_q, right_silence_bit_q};
					default: rsp_data_q <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// property bank
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			upper_limit_khz_q <= amsk_pkg::UPPER_RST;
			step_spacing_khz_q <= amsk_pkg::SPACE_RST;
			valid_snr_level_q <= amsk_pkg::SNR_RST;
			valid_strength_level_q <= amsk_pkg::RSSI_RST;
			loudness_level_q <= amsk_pkg::VOL_RST;
			left_silence_bit_q <= amsk_pkg::MUTE_RST[amsk_pkg::LEFT_BIT];
			right_silence_bit_q <= amsk_pkg::MUTE_RST[amsk_pkg::RIGHT_BIT];
		end else if (take && link.cmd_wr && pwr_q) begin
			unique case (link.cmd_prop)
				amsk_pkg::PROP_UPPER: upper_limit_khz_q <= link.cmd_data;
				amsk_pkg::PROP_SPACE: begin
					if (space_ok) begin
						step_spacing_khz_q <= link.cmd_data[3:0];
					end
				end
				amsk_pkg::PROP_SNR: valid_snr_level_q <= link.cmd_data[5:0];
				amsk_pkg::PROP_RSSI: begin
					valid_strength_level_q <= link.cmd_data[5:0];
				end
				amsk_pkg::PROP_VOL: loudness_level_q <= link.cmd_data[5:0];
				amsk_pkg::PROP_MUTE: begin
					left_silence_bit_q <= link.cmd_data[amsk_pkg::LEFT_BIT];
					right_silence_bit_q <= link.cmd_data[amsk_pkg::RIGHT_BIT];
				end
				default: ;
			endcase
		end
	end

	// one mute for both channels
	always_ff @(posedge clk) begin
		if (!rstn) begin
			audio_mute_q <= 1'b0;
		end else begin
			audio_mute_q <= left_silence_bit_q | right_silence_bit_q;
		end
	end

	// ----------------------------------------
	// seek and tune
	// ----------------------------------------
	always_comb begin
		meas_ok = (valid_snr_level_q == 6'h00 ||
			meas_snr >= valid_snr_level_q) &&
			(valid_strength_level_q == 6'h00 ||
			meas_rssi >= valid_strength_level_q);
		up_nxt = {1'b0, tuned_q} + {13'h0000, step_spacing_khz_q};
		dn_floor = {1'b0, band_low_khz} + {13'h0000, step_spacing_khz_q};
		dn_nxt = tuned_q - {12'h000, step_spacing_khz_q};
		past_top = up_nxt > {1'b0, upper_limit_khz_q};
		past_low = {1'b0, tuned_q} < dn_floor;
		hit_start = wrapped_q && (up_q ? (up_nxt >= {1'b0, start_q}) :
			(dn_nxt <= start_q));
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sk_q <= SK_IDLE;
			tuned_q <= 16'h0000;
			start_q <= 16'h0000;
			up_q <= 1'b1;
			wrap_q <= 1'b0;
			wrapped_q <= 1'b0;
			done_q <= 1'b0;
			valid_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (sk_q)
				SK_IDLE: begin
					if (pwr_q && tune_start) begin
						sk_q <= SK_TUNE;
						tuned_q <= tune_khz;
						valid_q <= 1'b0;
					end else if (pwr_q && seek_start) begin
						sk_q <= SK_SEEK;
						start_q <= tuned_q;
						up_q <= seek_up;
						wrap_q <= seek_wrap;
						wrapped_q <= 1'b0;
						valid_q <= 1'b0;
					end
				end
				SK_TUNE: begin
					if (meas_strobe) begin
						valid_q <= meas_ok;
						done_q <= 1'b1;
						sk_q <= SK_IDLE;
					end
				end
				SK_SEEK: begin
					if (meas_strobe) begin
						if (meas_ok && tuned_q != start_q) begin
							valid_q <= 1'b1;
							done_q <= 1'b1;
							sk_q <= SK_IDLE;
						end else if (hit_start) begin
							done_q <= 1'b1;
							sk_q <= SK_IDLE;
						end else if (up_q ? past_top : past_low) begin
							if (wrap_q) begin
								tuned_q <= up_q ? band_low_khz : upper_limit_khz_q;
								wrapped_q <= 1'b1;
							end else begin
								tuned_q <= up_q ? upper_limit_khz_q : band_low_khz;
								done_q <= 1'b1;
								sk_q <= SK_IDLE;
							end
						end else begin
							tuned_q <= up_q ? up_nxt[15:0] : dn_nxt;
						end
					end
				end
			endcase
		end
	end
endmodule : amsk_dev
`default_nettype wire

// File: logic/amsk_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module amsk_ctl (
	input wire logic clk,
	input wire logic rstn,
	amsk_if.ctl link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	typedef enum logic [1:0] {CT_IDLE, CT_SEND, CT_WAIT} amsk_ctl_e;

	amsk_ctl_e st_q;
	logic [15:0] prop_q;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic err_q;
	logic fixed_q;
	logic pwr_seen_q;
	logic fix_q;
	logic [amsk_pkg::INT_W-1:0] int_stat_q;
	logic [amsk_pkg::INT_W-1:0] int_mask_q;
	logic irq_q;
	logic cmd_valid_q;
	logic cmd_wr_q;
	logic [15:0] cmd_prop_q;
	logic [15:0] cmd_data_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic wr_go;
	logic bad_val;
	logic hit;
	logic [31:0] rd_mux;
	logic [amsk_pkg::INT_W-1:0] ev;

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign link.cmd_valid = cmd_valid_q;
	assign link.cmd_wr = cmd_wr_q;
	assign link.cmd_prop = cmd_prop_q;
	assign link.cmd_data = cmd_data_q;
	assign wr_go = psel && penable && pready_q && pwrite &&
		paddr == amsk_pkg::REG_CTRL && pwdata[amsk_pkg::CTRL_GO];

	// ----------------------------------------
	// apb slave, one wait state
	// ----------------------------------------
	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			amsk_pkg::REG_PROP: rd_mux = {16'h0000, prop_q};
			amsk_pkg::REG_WDATA: rd_mux = {16'h0000, wdata_q};
			amsk_pkg::REG_CTRL: rd_mux = 32'h0000_0000;
			amsk_pkg::REG_STATUS: rd_mux = {28'h0000000, fixed_q, err_q,
				link.powered, st_q != CT_IDLE};
			amsk_pkg::REG_RDATA: rd_mux = {16'h0000, rdata_q};
			amsk_pkg::REG_INT_STAT: rd_mux = {29'h00000000, int_stat_q};
			amsk_pkg::REG_INT_MASK: rd_mux = {29'h00000000, int_mask_q};
			default: begin
				rd_mux = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && penable && !pready_q) begin
			pready_q <= 1'b1;
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= !hit;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prop_q <= 16'h0000;
			wdata_q <= 16'h0000;
			int_mask_q <= '0;
		end else if (psel && penable && pready_q && pwrite) begin
			unique case (paddr)
				amsk_pkg::REG_PROP: prop_q <= pwdata[15:0];
				amsk_pkg::REG_WDATA: wdata_q <= pwdata[15:0];
				amsk_pkg::REG_INT_MASK: begin
					int_mask_q <= pwdata[amsk_pkg::INT_W-1:0];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb begin
		bad_val = 1'b0;
		if (prop_q == amsk_pkg::PROP_UPPER) begin
			bad_val = wdata_q < amsk_pkg::UPPER_MIN ||
				wdata_q > amsk_pkg::UPPER_MAX;
		end else if (prop_q == amsk_pkg::PROP_SPACE) begin
			bad_val = !(wdata_q[3:0] == amsk_pkg::SPACE_1 ||
				wdata_q[3:0] == amsk_pkg::SPACE_5 ||
				wdata_q[3:0] == amsk_pkg::SPACE_9 ||
				wdata_q[3:0] == amsk_pkg::SPACE_10) ||
				wdata_q[15:4] != 12'h000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwr_seen_q <= 1'b0;
		end else begin
			pwr_seen_q <= link.powered;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= CT_IDLE;
			cmd_valid_q <= 1'b0;
			cmd_wr_q <= 1'b0;
			cmd_prop_q <= 16'h0000;
			cmd_data_q <= 16'h0000;
			rdata_q <= 16'h0000;
			err_q <= 1'b0;
			fix_q <= 1'b0;
			fixed_q <= 1'b0;
			ev <= '0;
		end else begin
			ev <= '0;
			cmd_valid_q <= 1'b0;
			if (!link.powered) begin
				fixed_q <= 1'b0;
			end
			unique case (st_q)
				CT_IDLE: begin
					if (link.powered && !pwr_seen_q) begin
						st_q <= CT_SEND;
						fix_q <= 1'b1;
						cmd_wr_q <= 1'b1;
						cmd_prop_q <= amsk_pkg::PROP_UPPER;
						cmd_data_q <= amsk_pkg::UPPER_RST;
					end else if (wr_go) begin
						if (!link.powered ||
							(pwdata[amsk_pkg::CTRL_WR] && bad_val)) begin
							err_q <= 1'b1;
							ev[amsk_pkg::INT_ERR] <= 1'b1;
						end else begin
							st_q <= CT_SEND;
							fix_q <= 1'b0;
							cmd_wr_q <= pwdata[amsk_pkg::CTRL_WR];
							cmd_prop_q <= prop_q;
							cmd_data_q <= wdata_q;
						end
					end
				end
				CT_SEND: begin
					if (link.cts && !cmd_valid_q) begin
						cmd_valid_q <= 1'b1;
						st_q <= CT_WAIT;
					end
				end
				CT_WAIT: begin
					if (link.rsp_valid) begin
						st_q <= CT_IDLE;
						err_q <= link.rsp_err;
						if (!cmd_wr_q) begin
							rdata_q <= link.rsp_data;
						end
						if (fix_q) begin
							fixed_q <= !link.rsp_err;
							ev[amsk_pkg::INT_FIX] <= 1'b1;
						end else begin
							ev[amsk_pkg::INT_DONE] <= 1'b1;
						end
						ev[amsk_pkg::INT_ERR] <= link.rsp_err;
					end
				end
				default: st_q <= CT_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// interrupt status, write one to clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_stat_q <= '0;
		end else if (psel && penable && pready_q && pwrite &&
			paddr == amsk_pkg::REG_INT_STAT) begin
			int_stat_q <= (int_stat_q & ~pwdata[amsk_pkg::INT_W-1:0]) | ev;
		end else begin
			int_stat_q <= int_stat_q | ev;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(int_stat_q & int_mask_q);
		end
	end
endmodule : amsk_ctl
`default_nettype wire

// File: test/amsk_properties.sv
`timescale 1ns/10ps
`default_nettype none
module amsk_properties (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_prop,
	input wire logic [15:0] cmd_data,
	input wire logic cts,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [15:0] rsp_data,
	input wire logic powered
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic take;
	assign take = cmd_valid && cts;
	// ----------------------------------------
	// link handshake
	// ----------------------------------------
	a_busy_after_take: assert property (take |=> !cts[*4])
		else $error("cts not held low while busy");
	a_answer_delay: assert property (take |-> ##5 (rsp_valid && cts))
		else $error("answer not five edges after take");
	a_rsp_with_cts: assert property (rsp_valid |-> cts && !$past(cts))
		else $error("answer not paired with cts rise");
	a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
		else $error("answer longer than one cycle");
	a_err_zero_data: assert property (rsp_valid && rsp_err |->
		rsp_data == 16'h0000)
		else $error("refused answer carries data");
	a_send_when_ready: assert property (cmd_valid |-> cts && powered)
		else $error("command sent while busy or unpowered");
	// ----------------------------------------
	// values the controller may send
	// ----------------------------------------
	a_spacing_legal: assert property (cmd_valid && cmd_wr &&
		cmd_prop == amsk_pkg::PROP_SPACE |->
		cmd_data[3:0] inside {4'h1, 4'h5, 4'h9, 4'hA})
		else $error("illegal spacing sent");
	a_upper_legal: assert property (cmd_valid && cmd_wr &&
		cmd_prop == amsk_pkg::PROP_UPPER |->
		cmd_data >= amsk_pkg::UPPER_MIN && cmd_data <= amsk_pkg::UPPER_MAX)
		else $error("upper limit out of range sent");
	a_fix_on_power: assert property ($rose(powered) |-> ##[1:8]
		(cmd_valid && cmd_wr && cmd_prop == amsk_pkg::PROP_UPPER &&
		cmd_data == amsk_pkg::UPPER_RST))
		else $error("upper limit not rewritten after power-up");
endmodule : amsk_properties
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, se, ia, ib;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, rng;
	logic pwr_on, pwr_off, seek_start, seek_up, seek_wrap, tune_start;
	logic meas_strobe, seek_busy, seek_done, chan_valid, audio_mute;
	logic cts_irq, done_seen;
	logic [15:0] tune_khz, band_low_khz, tuned_khz, v;
	logic [5:0] meas_snr, meas_rssi, loudness_level;
	logic [63:0] exp_q[$];
	int err_total = 0;
	int n_compared = 0;
	int k;
	localparam logic [15:0] TP [6] = '{amsk_pkg::PROP_UPPER,
		amsk_pkg::PROP_SPACE, amsk_pkg::PROP_SNR, amsk_pkg::PROP_RSSI,
		amsk_pkg::PROP_VOL, amsk_pkg::PROP_MUTE};
	localparam logic [15:0] TR [6] = '{16'h06AE, 16'h000A, 16'h0005,
		16'h0019, 16'h003F, 16'h0000};
	localparam logic [15:0] TM [6] = '{16'hFFFF, 16'h000F, 16'h003F,
		16'h003F, 16'h003F, 16'h0003};
	localparam logic [15:0] SP [4] = '{16'h0001, 16'h0005, 16'h0009, 16'h000A};
	amsk_if link_if();
	amsk_dev amsk_dev_inst (.clk(clk), .rstn(rstn), .link(link_if.dev),
		.pwr_on(pwr_on), .pwr_off(pwr_off), .seek_start(seek_start),
		.seek_up(seek_up), .seek_wrap(seek_wrap), .tune_start(tune_start),
		.tune_khz(tune_khz), .band_low_khz(band_low_khz),
		.meas_strobe(meas_strobe), .meas_snr(meas_snr), .meas_rssi(meas_rssi),
		.tuned_khz(tuned_khz), .seek_busy(seek_busy), .seek_done(seek_done),
		.chan_valid(chan_valid), .loudness_level(loudness_level),
		.audio_mute(audio_mute), .cts_irq(cts_irq));
	amsk_ctl amsk_ctl_inst (.clk(clk), .rstn(rstn), .link(link_if.ctl),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq));
	amsk_properties amsk_properties_inst (.clk(clk), .rstn(rstn),
		.cmd_valid(link_if.cmd_valid), .cmd_wr(link_if.cmd_wr),
		.cmd_prop(link_if.cmd_prop), .cmd_data(link_if.cmd_data),
		.cts(link_if.cts), .rsp_valid(link_if.rsp_valid),
		.rsp_err(link_if.rsp_err), .rsp_data(link_if.rsp_data),
		.powered(link_if.powered));
	// ----------------------------------------
	// clock, checking, closing
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : chk
	task close_out;
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	// read results checked against the oldest note
	always @(posedge clk) begin
		if (seek_done === 1'b1)
			done_seen <= 1'b1;
		if (link_if.rsp_valid === 1'b1 || cts_irq === 1'b1)
			chk(32'(cts_irq), 32'(link_if.rsp_valid));
		if (psel && penable && !pwrite && pready === 1'b1) begin
			chk(prdata & exp_q[0][63:32], exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		close_out;
	end
	// ----------------------------------------
	// bus and command tasks
	// ----------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		exp_q.push_back({m, x});
		apb(1'b0, a, 32'h0);
	endtask : rx
	task poll(input logic [7:0] a, input logic [31:0] m);
		int i;
		for (i = 0; i < 60; i++) begin
			rx(a, 32'h0, 32'h0);
			if ((rd & m) != 32'h0)
				break;
		end
		chk(32'((rd & m) != 32'h0), 32'h1);
	endtask : poll
	task cmd(input logic w, input logic [15:0] p, input logic [15:0] d);
		apb(1'b1, amsk_pkg::REG_INT_STAT, 32'h7);
		apb(1'b1, amsk_pkg::REG_PROP, {16'h0, p});
		apb(1'b1, amsk_pkg::REG_WDATA, {16'h0, d});
		apb(1'b1, amsk_pkg::REG_CTRL, {30'h0, w, 1'b1});
		poll(amsk_pkg::REG_INT_STAT, 32'h3);
	endtask : cmd
	task pset(input logic [15:0] p, input logic [15:0] d, input logic bad);
		cmd(1'b1, p, d);
		rx(amsk_pkg::REG_INT_STAT, 32'h2, {30'h0, bad, 1'b0});
	endtask : pset
	task pget(input logic [15:0] p, input logic [15:0] x);
		cmd(1'b0, p, 16'h0);
		rx(amsk_pkg::REG_RDATA, 32'hFFFF_FFFF, {16'h0, x});
	endtask : pget
	task strobe(input logic [5:0] l);
		meas_snr <= l;
		meas_rssi <= l;
		meas_strobe <= 1'b1;
		@(posedge clk);
		meas_strobe <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : strobe
	task sk(input logic w, input int nlow);
		int i;
		done_seen <= 1'b0;
		seek_wrap <= w;
		seek_start <= 1'b1;
		@(posedge clk);
		seek_start <= 1'b0;
		for (i = 0; i < 8 && done_seen !== 1'b1; i++) begin
			if (i == 1)
				chk(32'(seek_busy), 32'h1);
			strobe(i < nlow ? 6'h00 : 6'h3F);
		end
		chk(32'(seek_busy), 32'h0);
	endtask : sk
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, psel, penable, pwrite, pwr_on, pwr_off, seek_start} = '0;
		{seek_wrap, tune_start, meas_strobe, done_seen} = '0;
		{paddr, pwdata, meas_snr, meas_rssi, tune_khz} = '0;
		seek_up = 1'b1;
		band_low_khz = 16'h03E8;
		rng = 32'h0000_0061;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		chk(32'(loudness_level), 32'h3F);
		chk(32'(audio_mute), 32'h0);
		rx(amsk_pkg::REG_STATUS, 32'h2, 32'h0);
		pset(amsk_pkg::PROP_VOL, 16'h0001, 1'b1);
		// irq follows the mask and clears
		apb(1'b1, amsk_pkg::REG_INT_MASK, 32'h7);
		repeat (2) @(negedge clk);
		ia = irq;
		apb(1'b1, amsk_pkg::REG_INT_MASK, 32'h0);
		repeat (2) @(negedge clk);
		ib = irq;
		chk(32'(ia), 32'h1);
		chk(32'(ib), 32'h0);
		apb(1'b1, amsk_pkg::REG_INT_STAT, 32'h7);
		apb(1'b1, amsk_pkg::REG_INT_MASK, 32'h7);
		repeat (2) @(negedge clk);
		chk(32'(irq), 32'h0);
		@(posedge clk);
		pwr_on <= 1'b1;
		@(posedge clk);
		pwr_on <= 1'b0;
		poll(amsk_pkg::REG_INT_STAT, 32'h4);
		rx(amsk_pkg::REG_STATUS, 32'hF, 32'hA);
		for (k = 0; k < 6; k++) begin
			pget(TP[k], TR[k]);
			rng = xs(rng);
			v = rng[15:0];
			if (k == 0)
				v = 16'(16'h0095 + rng % 32'h0000_5944);
			if (k == 1)
				v = SP[rng[1:0]];
			pset(TP[k], v, 1'b0);
			pget(TP[k], v & TM[k]);
		end
		for (k = 0; k < 4; k++) begin
			pset(amsk_pkg::PROP_SPACE, SP[k], 1'b0);
			pget(amsk_pkg::PROP_SPACE, SP[k]);
		end
		pset(amsk_pkg::PROP_SPACE, 16'h0003, 1'b1);
		pget(amsk_pkg::PROP_SPACE, 16'h000A);
		pset(amsk_pkg::PROP_UPPER, 16'h0094, 1'b1);
		pset(amsk_pkg::PROP_UPPER, 16'h59D9, 1'b1);
		pset(amsk_pkg::PROP_UPPER, 16'h59D8, 1'b0);
		pget(amsk_pkg::PROP_UPPER, 16'h59D8);
		for (k = 0; k < 4; k++) begin
			pset(amsk_pkg::PROP_MUTE, 16'(k), 1'b0);
			chk(32'(audio_mute), 32'(k != 0));
		end
		pset(amsk_pkg::PROP_VOL, 16'h0000, 1'b0);
		chk(32'(loudness_level), 32'h0);
		// seek from 1000 up to a 1030 limit, 10 apart
		pset(amsk_pkg::PROP_UPPER, 16'h0406, 1'b0);
		pset(amsk_pkg::PROP_SNR, 16'h0005, 1'b0);
		pset(amsk_pkg::PROP_RSSI, 16'h0019, 1'b0);
		tune_khz <= 16'h03E8;
		tune_start <= 1'b1;
		@(posedge clk);
		tune_start <= 1'b0;
		strobe(6'h00);
		sk(1'b0, 8);
		chk(32'(tuned_khz), 32'h0406);
		chk(32'(chan_valid), 32'h0);
		sk(1'b1, 1);
		chk(32'(tuned_khz), 32'h03E8);
		chk(32'(chan_valid), 32'h1);
		pset(amsk_pkg::PROP_SNR, 16'h0000, 1'b0);
		pset(amsk_pkg::PROP_RSSI, 16'h0000, 1'b0);
		sk(1'b0, 8);
		chk(32'(tuned_khz), 32'h03F2);
		chk(32'(chan_valid), 32'h1);
		seek_up <= 1'b0;
		sk(1'b0, 8);
		chk(32'(tuned_khz), 32'h03E8);
		cmd(1'b0, 16'h3400, 16'h0000);
		rx(amsk_pkg::REG_INT_STAT, 32'h2, 32'h2);
		rx(amsk_pkg::REG_RDATA, 32'hFFFF_FFFF, 32'h0);
		rx(8'h1C, 32'hFFFF_FFFF, 32'h0);
		chk(32'(se), 32'h1);
		chk(rd, 32'h0);
		@(posedge clk);
		pwr_off <= 1'b1;
		@(posedge clk);
		pwr_off <= 1'b0;
		pset(amsk_pkg::PROP_VOL, 16'h0001, 1'b1);
		rx(amsk_pkg::REG_STATUS, 32'h2, 32'h0);
		close_out;
	end
endmodule : tb
`default_nettype wire
